// file: rtl/ftp_flash_timing_protection.sv
// Function
// - high and low bytes form sixteen bit value
// - frequency value in kHz sets operation timing
// - read protect blocks debugger code readout
// - read and write options give three levels
// - options, lock, page redundancy, sector guard combined
// - oscillator trim byte read write, kept through reset
// - detector trim low bits, kept through reset
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ftp_flash_timing_protection (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [7:0] rdData,
   input wire logic readProtectOption,
   input wire logic writeProtectOption,
   input wire logic dbgReadReq,
   input wire logic [7:0] dbgCodeData,
   output logic [7:0] dbgReadData,
   output logic dbgReadDenied,
   output logic [2:0] opSector,
   output logic flashProgActive,
   output logic flashEraseActive,
   output logic [7:0] oscillatorTrimValue,
   output logic [4:0] lowVoltageTrimValue
);
   import ftp_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // option synchronisers and protection level
   logic [1:0] optMeta_q, optSync_q;
   ftp_level_t level;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         optMeta_q <= 2'b00;
         optSync_q <= 2'b00;
      end else begin
         optMeta_q <= {readProtectOption, writeProtectOption};
         optSync_q <= optMeta_q;
      end
   end
   always_comb begin
      case (optSync_q)
         2'b00: level = PROT_NONE;
         2'b01: level = PROT_WRITE;
         default: level = PROT_READ;
      endcase
   end
   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] freqHigh_q, freqHigh_d, freqLow_q, freqLow_d;
   logic [7:0] secProt_q, secProt_d, pageSel_q, pageSel_d;
   logic [7:0] pageChk_q, pageChk_d;
   logic [7:0] rsvTrim_q, rsvTrim_d, oscTrim_q, oscTrim_d, lvdTrim_q, lvdTrim_d;
   logic [7:0] rdData_q, rdData_d;
   logic freqSet_q, freqSet_d;
   ftp_lock_t lock_q, lock_d;
   logic [15:0] opCnt_q, opCnt_d;
   logic prog_q, prog_d, erase_q, erase_d, refused_q, refused_d;
   logic [15:0] flashClockKhz;
   logic [21:0] opCycles;
   logic freqOk, pageOk, sectorOpen, startReq, startOk;
   assign flashClockKhz = {freqHigh_q, freqLow_q};
   // cycles = khz * time_us / 1000, rounded down
   assign opCycles = 22'((32'(flashClockKhz) * OP_TIME_US) / 1000);
   assign freqOk = (flashClockKhz >= FREQ_MIN_KHZ) && (flashClockKhz <= FREQ_MAX_KHZ);
   assign pageOk = (pageChk_q == ~pageSel_q);
   assign sectorOpen = ~secProt_q[pageSel_q[7:5]];
   assign startReq = wrStb && addr == CONTROL_OFS
      && (wrData[CTL_PROG_BIT] || wrData[CTL_ERASE_BIT]);
   assign startOk = freqSet_q && freqOk && pageOk && sectorOpen
      && lock_q == ST_OPEN && level == PROT_NONE && !prog_q && !erase_q;
   always_comb begin
      freqHigh_d = freqHigh_q;
      freqLow_d = freqLow_q;
      secProt_d = secProt_q;
      pageSel_d = pageSel_q;
      pageChk_d = pageChk_q;
      rsvTrim_d = rsvTrim_q;
      oscTrim_d = oscTrim_q;
      lvdTrim_d = lvdTrim_q;
      freqSet_d = freqSet_q;
      lock_d = lock_q;
      opCnt_d = opCnt_q;
      prog_d = prog_q;
      erase_d = erase_q;
      refused_d = refused_q;
      rdData_d = 8'h00;
      if (prog_q || erase_q) begin
         if (opCnt_q <= 16'h0001) begin
            prog_d = 1'b0;
            erase_d = 1'b0;
            opCnt_d = 16'h0000;
         end else begin
            opCnt_d = opCnt_q - 16'h0001;
         end
      end
      if (wrStb) begin
         case (addr)
            FREQ_HIGH_OFS: begin
               freqHigh_d = wrData;
               freqSet_d = 1'b1;
            end
            FREQ_LOW_OFS: begin
               freqLow_d = wrData;
               freqSet_d = 1'b1;
            end
            SECTOR_PROT_OFS: begin
               if (lock_q == ST_OPEN) begin
                  secProt_d = secProt_q | wrData;
               end
            end
            PAGE_SEL_OFS: pageSel_d = wrData;
            PAGE_CHECK_OFS: begin
               pageChk_d = wrData;
               case (lock_q)
                  ST_IDLE: lock_d = (wrData == UNLOCK_KEY1) ? ST_KEY1 : ST_IDLE;
                  ST_KEY1: lock_d = (wrData == UNLOCK_KEY2) ? ST_OPEN : ST_IDLE;
                  default: lock_d = ST_IDLE;
               endcase
            end
            CONTROL_OFS: begin
               if (startReq && startOk) begin
                  prog_d = wrData[CTL_PROG_BIT];
                  erase_d = !wrData[CTL_PROG_BIT];
                  opCnt_d = (opCycles == 22'd0) ? 16'h0001 : opCycles[15:0];
                  refused_d = 1'b0;
                  lock_d = ST_IDLE;
               end else if (startReq) begin
                  refused_d = 1'b1;
                  lock_d = ST_IDLE;
               end
            end
            RESERVED_TRIM_OFS: rsvTrim_d = wrData;
            OSC_TRIM_OFS: oscTrim_d = wrData;
            LOW_VOLTAGE_TRIM_VALUE_OFS: lvdTrim_d = wrData;
            default: ;
         endcase
      end
      if (rdStb) begin
         case (addr)
            FREQ_HIGH_OFS: rdData_d = freqHigh_q;
            FREQ_LOW_OFS: rdData_d = freqLow_q;
            STATUS_OFS: begin
               rdData_d[ST_BUSY_BIT] = prog_q || erase_q;
               rdData_d[ST_REFUSED_BIT] = refused_q;
               rdData_d[ST_UNLOCKED_BIT] = (lock_q == ST_OPEN);
               rdData_d[ST_LEVEL_LSB +: 2] = level;
            end
            SECTOR_PROT_OFS: rdData_d = secProt_q;
            PAGE_SEL_OFS: rdData_d = pageSel_q;
            PAGE_CHECK_OFS: rdData_d = pageChk_q;
            RESERVED_TRIM_OFS: rdData_d = rsvTrim_q;
            OSC_TRIM_OFS: rdData_d = oscTrim_q;
            LOW_VOLTAGE_TRIM_VALUE_OFS: rdData_d = lvdTrim_q;
            default: rdData_d = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         freqHigh_q <= FREQ_RST[15:8];
         freqLow_q <= FREQ_RST[7:0];
         secProt_q <= SECTOR_PROT_RST;
         pageSel_q <= 8'h00;
         pageChk_q <= 8'h00;
         freqSet_q <= 1'b0;
         lock_q <= ST_IDLE;
         opCnt_q <= 16'h0000;
         prog_q <= 1'b0;
         erase_q <= 1'b0;
         refused_q <= 1'b0;
         rdData_q <= 8'h00;
      end else begin
         freqHigh_q <= freqHigh_d;
         freqLow_q <= freqLow_d;
         secProt_q <= secProt_d;
         pageSel_q <= pageSel_d;
         pageChk_q <= pageChk_d;
         freqSet_q <= freqSet_d;
         lock_q <= lock_d;
         opCnt_q <= opCnt_d;
         prog_q <= prog_d;
         erase_q <= erase_d;
         refused_q <= refused_d;
         rdData_q <= rdData_d;
      end
   end
   // trim bytes are not touched by reset
   always_ff @(posedge clk) begin
      rsvTrim_q <= rsvTrim_d;
      oscTrim_q <= oscTrim_d;
      lvdTrim_q <= lvdTrim_d;
   end
   assign rdData = rdData_q;
   assign flashProgActive = prog_q;
   assign flashEraseActive = erase_q;
   assign opSector = pageSel_q[7:5];
   assign oscillatorTrimValue = oscTrim_q;
   assign lowVoltageTrimValue = lvdTrim_q[LOW_VOLTAGE_TRIM_VALUE_W-1:0];
   ////////////////////////////////////////////////////////////////////
   // debugger readout gate
   logic [7:0] dbgData_q, dbgData_d;
   logic dbgDenied_q, dbgDenied_d;
   always_comb begin
      dbgData_d = dbgData_q;
      dbgDenied_d = 1'b0;
      if (dbgReadReq) begin
         dbgDenied_d = optSync_q[1];
         dbgData_d = optSync_q[1] ? 8'h00 : dbgCodeData;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dbgData_q <= 8'h00;
         dbgDenied_q <= 1'b0;
      end else begin
         dbgData_q <= dbgData_d;
         dbgDenied_q <= dbgDenied_d;
      end
   end
   assign dbgReadData = dbgData_q;
   assign dbgReadDenied = dbgDenied_q;
   ////////////////////////////////////////////////////////////////////
   // assertions
   a_readout_blocked: assert property (@(posedge clk) disable iff (rst)
      dbgReadReq && optSync_q[1] |=> dbgReadDenied && dbgReadData == 8'h00)
      else $error("debug read returned code under read protect");
   a_start_needs_freq: assert property (@(posedge clk) disable iff (rst)
      $rose(prog_q || erase_q) |-> $past(freqSet_q) && $past(freqOk))
      else $error("operation started without valid frequency");
   a_freq_join: assert property (@(posedge clk) disable iff (rst)
      rdStb && addr == FREQ_HIGH_OFS |=> rdData == flashClockKhz[15:8])
      else $error("high byte readback wrong");
   a_range_refuse: assert property (@(posedge clk) disable iff (rst)
      startReq && !freqOk |=> refused_q && !$rose(prog_q || erase_q))
      else $error("out of range start not refused");
   a_level_blocks: assert property (@(posedge clk) disable iff (rst)
      startReq && level != PROT_NONE |=> !$rose(prog_q || erase_q))
      else $error("protected level allowed operation");
   a_lock_needed: assert property (@(posedge clk) disable iff (rst)
      startReq && (lock_q != ST_OPEN || !pageOk || !sectorOpen) |=> refused_q)
      else $error("start accepted without lock and page check");
   a_timing_end: assert property (@(posedge clk) disable iff (rst)
      (prog_q || erase_q) && opCnt_q == 16'h0001 |=> !prog_q && !erase_q)
      else $error("operation did not end on count");
   a_osc_trim: assert property (@(posedge clk) disable iff (rst)
      wrStb && addr == OSC_TRIM_OFS |=> oscillatorTrimValue == $past(wrData))
      else $error("oscillator trim not written");
   a_low_voltage_trim_value: assert property (@(posedge clk) disable iff (rst)
      wrStb && addr == LOW_VOLTAGE_TRIM_VALUE_OFS |=> lowVoltageTrimValue == $past(wrData[4:0]))
      else $error("detector trim not written");
endmodule : ftp_flash_timing_protection
`default_nettype wire

// file: rtl/ftp_pkg.sv
package ftp_pkg;
   // register map, byte offsets of the local control port
   localparam logic [7:0] FREQ_HIGH_OFS = 8'h00;
   localparam logic [7:0] FREQ_LOW_OFS = 8'h01;
   localparam logic [7:0] CONTROL_OFS = 8'h02;
   localparam logic [7:0] STATUS_OFS = 8'h03;
   localparam logic [7:0] SECTOR_PROT_OFS = 8'h04;
   localparam logic [7:0] PAGE_SEL_OFS = 8'h05;
   localparam logic [7:0] PAGE_CHECK_OFS = 8'h06;
   localparam logic [7:0] RESERVED_TRIM_OFS = 8'h21;
   localparam logic [7:0] OSC_TRIM_OFS = 8'h22;
   localparam logic [7:0] LOW_VOLTAGE_TRIM_VALUE_OFS = 8'h23;
   // control register fields
   localparam int CTL_PROG_BIT = 0;
   localparam int CTL_ERASE_BIT = 1;
   // status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_REFUSED_BIT = 1;
   localparam int ST_UNLOCKED_BIT = 2;
   localparam int ST_LEVEL_LSB = 3;
   // unlock key sequence
   localparam logic [7:0] UNLOCK_KEY1 = 8'h73;
   localparam logic [7:0] UNLOCK_KEY2 = 8'h8C;
   // reset values
   localparam logic [7:0] SECTOR_PROT_RST = 8'h00;
   localparam logic [15:0] FREQ_RST = 16'h0000;
   // low_voltage_trim_value field width within its byte
   localparam int LOW_VOLTAGE_TRIM_VALUE_W = 5;
   // valid flash clock range in kHz
   localparam logic [15:0] FREQ_MIN_KHZ = 16'd32;
   localparam logic [15:0] FREQ_MAX_KHZ = 16'd20000;
   // one operation lasts this many microseconds
   localparam int OP_TIME_US = 40;
   // protection levels
   typedef enum logic [1:0] {
      PROT_NONE = 2'b00,
      PROT_WRITE = 2'b01,
      PROT_READ = 2'b11,
      PROT_FULL = 2'b10
   } ftp_level_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_KEY1 = 2'b01,
      ST_OPEN = 2'b11
   } ftp_lock_t;
endpackage : ftp_pkg

// file: dv/ftp_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ftp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wrData = 8'h00;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic readProtectOption = 1'b0;
   logic writeProtectOption = 1'b0;
   logic dbgReadReq = 1'b0;
   logic [7:0] dbgCodeData = 8'h00;
   logic [7:0] rdData;
   logic [7:0] dbgReadData;
   logic dbgReadDenied;
   logic [2:0] opSector;
   logic flashProgActive;
   logic flashEraseActive;
   logic [7:0] oscillatorTrimValue;
   logic [4:0] lowVoltageTrimValue;
   logic [7:0] rv;
   int nMismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////////
   ftp_flash_timing_protection ftp_flash_timing_protection_inst (
      .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
      .rdStb(rdStb), .rdData(rdData), .readProtectOption(readProtectOption),
      .writeProtectOption(writeProtectOption), .dbgReadReq(dbgReadReq),
      .dbgCodeData(dbgCodeData), .dbgReadData(dbgReadData),
      .dbgReadDenied(dbgReadDenied), .opSector(opSector),
      .flashProgActive(flashProgActive), .flashEraseActive(flashEraseActive),
      .oscillatorTrimValue(oscillatorTrimValue),
      .lowVoltageTrimValue(lowVoltageTrimValue));
   ////////////////////////////////////////////////////////////////////////////
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         nMismatch = nMismatch + 1;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         nMismatch = nMismatch + 1;
         $display("[ERR] t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask : rd
   task automatic dbg(input logic [7:0] code, input logic deny);
      @(posedge clk);
      dbgReadReq <= 1'b1;
      dbgCodeData <= code;
      @(posedge clk);
      dbgReadReq <= 1'b0;
      #1 check({7'h00, dbgReadDenied}, {7'h00, deny}, "debug denied");
      check(dbgReadData, deny ? 8'h00 : code, "debug data");
   endtask : dbg
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
      if (nMismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   localparam logic RP_TAB [3] = '{1'b0, 1'b0, 1'b1};
   localparam logic WP_TAB [3] = '{1'b0, 1'b1, 1'b0};
   localparam int OP_CYC = 20000 * OP_TIME_US / 1000;
   localparam int OP_CYC_MIN = 32 * OP_TIME_US / 1000;
   logic [7:0] rvRsv;
   task automatic unlock();
      wr(PAGE_CHECK_OFS, UNLOCK_KEY1);
      wr(PAGE_CHECK_OFS, UNLOCK_KEY2);
   endtask : unlock
   localparam logic [1:0] LVL_TAB [3] = '{2'b00, 2'b01, 2'b11};
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // trim bytes written, read back and kept across a reset
      wr(OSC_TRIM_OFS, 8'hA5);
      wr(LOW_VOLTAGE_TRIM_VALUE_OFS, 8'hF3);
      rd(OSC_TRIM_OFS, rv);
      check(rv, 8'hA5, "osc trim read");
      rd(LOW_VOLTAGE_TRIM_VALUE_OFS, rv);
      check(rv, 8'hF3, "low_voltage_trim_value read");
      rd(RESERVED_TRIM_OFS, rvRsv);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check(oscillatorTrimValue, 8'hA5, "osc trim kept");
      check({3'h0, lowVoltageTrimValue}, 8'h13, "low_voltage_trim_value kept");
      rd(OSC_TRIM_OFS, rv);
      check(rv, 8'hA5, "osc trim read after reset");
      rd(RESERVED_TRIM_OFS, rv);
      check(rv, rvRsv, "reserved trim kept");
      $display("test trim done");
      // protection levels and debugger readout
      @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         readProtectOption <= RP_TAB[i];
         writeProtectOption <= WP_TAB[i];
         repeat (3) @(posedge clk);
         rd(STATUS_OFS, rv);
         check({6'h00, rv[ST_LEVEL_LSB +: 2]}, {6'h00, LVL_TAB[i]}, "level");
         dbg(8'h5A + 8'(i), RP_TAB[i]);
         wr(CONTROL_OFS, 8'h01);
      end
      readProtectOption <= 1'b0;
      writeProtectOption <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check({6'h00, flashProgActive, flashEraseActive}, 8'h00, "start refused");
      $display("test levels done");
      // accepted program, then erase at the lowest clock
      wr(FREQ_HIGH_OFS, 8'h4E);
      wr(FREQ_LOW_OFS, 8'h20);
      rd(FREQ_HIGH_OFS, rv);
      check(rv, 8'h4E, "freq high read");
      rd(FREQ_LOW_OFS, rv);
      check(rv, 8'h20, "freq low read");
      wr(PAGE_SEL_OFS, 8'h73);
      #1 check({5'h00, opSector}, 8'h03, "sector of page");
      unlock();
      rd(STATUS_OFS, rv);
      check(rv, 8'h06, "unlocked status");
      wr(CONTROL_OFS, 8'h01);
      #1 check({6'h00, flashProgActive, flashEraseActive}, 8'h02, "program started");
      rd(STATUS_OFS, rv);
      check(rv, 8'h01, "busy and relocked");
      repeat (OP_CYC - 3) @(posedge clk);
      #1 check({7'h00, flashProgActive}, 8'h01, "program still on");
      @(posedge clk);
      #1 check({7'h00, flashProgActive}, 8'h00, "program ended");
      wr(FREQ_HIGH_OFS, 8'h00);
      wr(FREQ_LOW_OFS, 8'h20);
      unlock();
      wr(CONTROL_OFS, 8'h02);
      #1 check({6'h00, flashProgActive, flashEraseActive}, 8'h01, "erase started");
      repeat (OP_CYC_MIN) @(posedge clk);
      #1 check({7'h00, flashEraseActive}, 8'h00, "erase ended");
      // refusals: clock out of range, protected sector
      wr(FREQ_LOW_OFS, 8'h10);
      unlock();
      wr(CONTROL_OFS, 8'h02);
      rd(STATUS_OFS, rv);
      check(rv, 8'h02, "slow clock refused");
      check({7'h00, flashEraseActive}, 8'h00, "no erase");
      wr(FREQ_HIGH_OFS, 8'h4E);
      wr(FREQ_LOW_OFS, 8'h21);
      unlock();
      wr(CONTROL_OFS, 8'h01);
      rd(STATUS_OFS, rv);
      check(rv, 8'h02, "fast clock refused");
      wr(FREQ_LOW_OFS, 8'h20);
      unlock();
      wr(SECTOR_PROT_OFS, 8'h08);
      wr(CONTROL_OFS, 8'h01);
      repeat (3) begin
         @(posedge clk);
         #1 check({6'h00, flashProgActive, flashEraseActive}, 8'h00, "no op");
      end
      rd(STATUS_OFS, rv);
      check(rv, 8'h02, "sector refused and relocked");
      wr(SECTOR_PROT_OFS, 8'h01);
      rd(SECTOR_PROT_OFS, rv);
      check(rv, 8'h08, "sector guard locked");
      rd(8'h40, rv);
      check(rv, 8'h00, "unmapped read");
      $display("test protection done");
      end_sim();
   end
endmodule : tb
`default_nettype wire
